// *** logic/mmc_counter.sv ***
// Multi-mode measurement counter core with APB register access
`timescale 1ns/1ns
`include "mmc_cfg.svh"

// Function
// - Frequency and period both time channel A
// - Timebase counted, one cycle per count
// - Ratio counts both until N A events
// - Ratio spans 1e-9 to 1e9 range
// - Width from selected A edge to opposite
// - Interval from A edge to B edge
// - Dither timebase in width, interval, rise/fall
// - Null captures result, subtracts it afterwards
// - Averaging change keeps offset; re-null recaptures
// - Any function selection leaves null mode
// - Null result takes the coarser resolution
// - Count B events inside A pulses
// - Manual timing in hundredths, no averaging
// - Reset press and release restarts timing
// - Manual mode enters stopped, indicator lit
// - Totalize A between start/stop presses
// - Exponent zero or auto gives whole numbers
// - Scale exponent changeable after count ends
// - Sum adds B after first A
// - Difference subtracts B after first A
// - Slope picks rise or fall; auto levels
// - Rise/fall copies A conditioning to B
// - Auto level in rise/fall moves to 50%
module mmc_counter #(
  parameter int HUNDREDTH_CYCLES = `MMC_HUNDREDTH_NS / `MMC_CLK_PERIOD_NS
) (
  input  wire logic                 CLOCK_I,      // Timebase clock
  input  wire logic                 NRST_I,       // Synchronous reset, active low
  input  wire mmc_pkg::mmc_apb_req_t APB_I,       // APB request
  output mmc_pkg::mmc_apb_rsp_t     APB_O,        // APB answer
  input  wire logic                 CH_A_I,       // Conditioned channel A
  input  wire logic                 CH_B_I,       // Conditioned channel B
  input  wire logic                 START_STOP_I, // Start/stop button level
  input  wire logic                 RESET_BTN_I,  // Reset button level
  output logic                      DITHER_EN_O,  // Phase modulation on
  output logic                      STOP_LED_O,   // Start/stop indicator
  output logic                      COPY_A_TO_B_O,// Mirror A conditioning on B
  output logic [1:0]                LEVEL_SEL_O,  // 01: 10/90 %, 10: 50 %
  output logic                      DONE_O        // Measurement complete
);
  import mmc_pkg::*;

  localparam int CW = `MMC_CNT_W;
  localparam logic [23:0] PRE_LAST = 24'(HUNDREDTH_CYCLES - 1);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Edge of the chosen polarity
  function automatic logic edge_of(input logic cur, input logic prv, input logic pos);
    edge_of = pos ? (cur & ~prv) : (~cur & prv);
  endfunction : edge_of

  // Ten to a non-negative power
  function automatic logic [CW-1:0] pow10(input logic [3:0] e);
    logic [CW-1:0] r;
    r = CW'(1);
    for (int i = 0; i < 9; i++)
      if (4'(i) < e)
        r = CW'(r * CW'(10));
    pow10 = r;
  endfunction : pow10

  // Negative exponent (auto) clamps to zero
  function automatic logic [3:0] clamp_exp(input logic [4:0] e);
    clamp_exp = e[4] ? 4'h0 : e[3:0];
  endfunction : clamp_exp

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  mmc_mode_t     mode;          // Active function
  mmc_state_t    state;         // Sequencer state
  logic          slope_a;       // A slope, 1 = positive
  logic          slope_b_cfg;   // B slope as written
  logic [4:0]    avg_exp;       // Averaging exponent, -1 = auto
  logic [CW-1:0] a_cnt;         // A events or pulses counted
  logic [CW-1:0] m_cnt;         // Timebase, B or total count
  logic [CW-1:0] a_hold;        // Held A count
  logic [CW-1:0] m_hold;        // Held main count
  logic [CW-1:0] offset;        // Null offset
  logic [3:0]    off_res;       // Resolution of the offset
  logic          null_on;       // Null mode active
  logic          done;          // Result waiting for the processor
  logic          auto_lvl;      // Auto level in rise/fall
  logic          gate;          // Pulse or interval gate open
  logic          b_en;          // B counting enabled in totalize
  logic [23:0]   pre;           // Hundredth-second prescaler
  logic          a_q, b_q;      // Previous channel levels
  logic          ss_q, rst_q;   // Previous button levels
  logic          dith;          // Random bit
  logic          a_sel, a_opp;  // A edges, selected and opposite
  logic          b_sel;         // B edge, selected
  logic          slope_b;       // Effective B slope
  logic          ss_press;      // Start/stop pressed
  logic          rst_rel;       // Reset released
  logic          pulse_mode;    // Gated pulse/interval family
  logic          press_mode;    // Button driven family
  logic [CW-1:0] n_target;      // Events to accumulate
  logic          last_a;        // This A event completes the run
  logic          enter_hold;    // Run ends this cycle
  logic          hold_pend;     // Run ended on the previous edge
  logic          wr, rd_setup;  // Bus strobes
  logic          wr_mode;       // Function selection written
  logic          cmd_null;      // Null request
  logic          cmd_ack;       // Result taken
  logic [3:0]    cur_res;       // Resolution of current setting
  logic [3:0]    res_exp;       // Reported resolution
  logic [3:0]    scale_exp;     // Totalize display scale
  logic [CW-1:0] net;           // Held result less offset
  logic [31:0]   status;        // Status word
  logic [31:0]   next_rdata;    // Read mux
  logic          next_err;      // Unmapped address

  // ----------------------------------------------------------------
  // Random source
  // ----------------------------------------------------------------
  mmc_prng u_prng (
    .CLOCK_I (CLOCK_I),
    .NRST_I  (NRST_I),
    .EN_I    (DITHER_EN_O),
    .BIT_O   (dith)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign wr       = APB_I.psel & APB_I.penable & APB_I.pwrite;
  assign rd_setup = APB_I.psel & ~APB_I.penable;
  // An illegal code is no selection, so it must not clear null, done or counts
  assign wr_mode  = wr & (APB_I.paddr == `MMC_OFF_MODE) & $onehot(APB_I.pwdata[10:0]);
  assign cmd_null = wr & (APB_I.paddr == `MMC_OFF_CMD) & APB_I.pwdata[`MMC_CMD_NULL];
  assign cmd_ack  = wr & (APB_I.paddr == `MMC_OFF_CMD) & APB_I.pwdata[`MMC_CMD_ACK];

  // Rise/fall measures both edges with the A slope
  assign slope_b  = (mode == MD_RISEFALL) ? slope_a : slope_b_cfg;
  assign a_sel    = edge_of(CH_A_I, a_q, slope_a);
  assign a_opp    = edge_of(CH_A_I, a_q, ~slope_a);
  assign b_sel    = edge_of(CH_B_I, b_q, slope_b);
  assign ss_press = START_STOP_I & ~ss_q;
  assign rst_rel  = ~RESET_BTN_I & rst_q;

  assign pulse_mode = mode inside {MD_WIDTH, MD_INTERVAL, MD_EVENTS, MD_RISEFALL};
  assign press_mode = mode inside {MD_MANUAL, MD_TOT_A, MD_TOT_SUM, MD_TOT_DIFF};
  assign n_target   = pow10(clamp_exp(avg_exp));
  assign last_a     = (a_cnt + CW'(1)) == n_target;

  // Run ends on the Nth A event, pulse close, or a stop press
  always_comb
  begin
    enter_hold = 1'b0;
    if (state == ST_RUN)
    begin
      if (press_mode)
        enter_hold = ss_press & ~RESET_BTN_I;
      else if (pulse_mode)
        enter_hold = gate & last_a &
          ((mode inside {MD_WIDTH, MD_EVENTS}) ? a_opp : b_sel);
      else
        enter_hold = a_sel & last_a;
    end
  end

  // ----------------------------------------------------------------
  // Input history
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I)
  begin
    if (!NRST_I)
    begin
      a_q   <= 1'b0;
      b_q   <= 1'b0;
      ss_q  <= 1'b0;
      rst_q <= 1'b0;
    end
    else
    begin
      a_q   <= CH_A_I;
      b_q   <= CH_B_I;
      ss_q  <= START_STOP_I;
      rst_q <= RESET_BTN_I;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // The exponent may change at any time, even while a count is held
  always_ff @(posedge CLOCK_I)
  begin
    if (!NRST_I)
    begin
      mode        <= MD_FREQ;
      slope_a     <= `MMC_SLOPE_RST;
      slope_b_cfg <= `MMC_SLOPE_RST;
      avg_exp     <= `MMC_EXP_RST;
    end
    else if (wr & (APB_I.paddr == `MMC_OFF_CONF))
    begin
      slope_a     <= APB_I.pwdata[`MMC_CONF_SLOPE_A];
      slope_b_cfg <= APB_I.pwdata[`MMC_CONF_SLOPE_B];
      avg_exp     <= APB_I.pwdata[`MMC_CONF_EXP_HI:`MMC_CONF_EXP_LO];
    end
    else if (wr_mode)
    begin
      // Illegal codes are ignored and the old function kept
      unique case (APB_I.pwdata[10:0])
        MD_FREQ, MD_PERIOD, MD_RATIO, MD_WIDTH, MD_INTERVAL, MD_EVENTS,
        MD_MANUAL, MD_TOT_A, MD_TOT_SUM, MD_TOT_DIFF, MD_RISEFALL:
          mode <= mmc_mode_t'(APB_I.pwdata[10:0]);
        default:
          mode <= mode;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Null offset
  // ----------------------------------------------------------------
  // Averaging writes do not touch the offset; only a selection clears null mode
  always_ff @(posedge CLOCK_I)
  begin
    if (!NRST_I)
    begin
      null_on <= 1'b0;
      offset  <= '0;
      off_res <= 4'h0;
    end
    else if (wr_mode)
      null_on <= 1'b0;
    else if (cmd_null)
    begin
      null_on <= 1'b1;
      offset  <= m_hold;
      off_res <= cur_res;
    end
  end

  // ----------------------------------------------------------------
  // Level control for rise/fall
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I)
  begin
    if (!NRST_I)
      auto_lvl <= 1'b0;
    else if (wr_mode)
      auto_lvl <= 1'b0;
    else if (wr & (APB_I.paddr == `MMC_OFF_CMD) & APB_I.pwdata[`MMC_CMD_AUTOLVL])
      auto_lvl <= (mode == MD_RISEFALL);
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Manual and totalize wait for a press; others for the first A edge
  always_ff @(posedge CLOCK_I)
  begin
    if (!NRST_I)
      state <= ST_WAIT;
    else if (wr_mode)
      state <= ST_WAIT;
    else if ((mode == MD_MANUAL) & rst_rel)
      state <= ST_RUN;
    else
    begin
      unique case (state)
        ST_WAIT:
          if (press_mode ? (ss_press & ~RESET_BTN_I) : a_sel)
            state <= ST_RUN;
        ST_RUN:
          if (enter_hold)
            state <= ST_HOLD;
        ST_HOLD:
          if (cmd_ack)
            state <= ST_WAIT;
      endcase
    end
  end

  // Gate for width, interval, events and rise/fall
  always_ff @(posedge CLOCK_I)
  begin
    if (!NRST_I || wr_mode || state != ST_RUN && state != ST_WAIT)
      gate <= 1'b0;
    else if (pulse_mode && state == ST_WAIT)
      gate <= a_sel;
    else if (pulse_mode && gate)
      gate <= (mode inside {MD_WIDTH, MD_EVENTS}) ? ~a_opp : ~b_sel;
    else if (pulse_mode)
      gate <= a_sel;
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  // Counts are cleared on selection, on reset press in manual mode, and on each new start
  always_ff @(posedge CLOCK_I)
  begin
    if (!NRST_I || wr_mode || ((mode == MD_MANUAL) && RESET_BTN_I))
    begin
      a_cnt <= '0;
      m_cnt <= '0;
      b_en  <= 1'b0;
      pre   <= '0;
    end
    else if (state == ST_WAIT)
    begin
      a_cnt <= '0;
      m_cnt <= '0;
      b_en  <= 1'b0;
      pre   <= '0;
    end
    else if (state == ST_RUN)
    begin
      unique case (mode)
        MD_FREQ, MD_PERIOD:
        begin
          m_cnt <= m_cnt + CW'(1);
          if (a_sel)
            a_cnt <= a_cnt + CW'(1);
        end
        MD_RATIO:
        begin
          // Wide counters keep both extremes of the quotient exact
          if (b_sel)
            m_cnt <= m_cnt + CW'(1);
          if (a_sel)
            a_cnt <= a_cnt + CW'(1);
        end
        MD_WIDTH, MD_INTERVAL, MD_RISEFALL:
        begin
          // A random extra count on each open-gate cycle except the one that ends the run dithers the timebase
          if (gate)
            m_cnt <= m_cnt + CW'(1) + CW'(enter_hold | ~gate ? 1'b0 : dith);
          if (gate && ((mode == MD_WIDTH) ? a_opp : b_sel))
            a_cnt <= a_cnt + CW'(1);
        end
        MD_EVENTS:
        begin
          if (gate && b_sel)
            m_cnt <= m_cnt + CW'(1);
          if (gate && a_opp)
            a_cnt <= a_cnt + CW'(1);
        end
        MD_MANUAL:
        begin
          // Exponent plays no part: one count per hundredth second
          if (pre == PRE_LAST)
          begin
            pre   <= '0;
            m_cnt <= m_cnt + CW'(1);
          end
          else
            pre <= pre + 24'h000001;
        end
        MD_TOT_A:
          if (CH_A_I & ~a_q)
            m_cnt <= m_cnt + CW'(1);
        MD_TOT_SUM, MD_TOT_DIFF:
        begin
          if (CH_A_I & ~a_q)
          begin
            a_cnt <= a_cnt + CW'(1);
            b_en  <= 1'b1;
          end
          if (mode == MD_TOT_SUM)
            m_cnt <= m_cnt + CW'(CH_A_I & ~a_q) + CW'(b_en & CH_B_I & ~b_q);
          else
            m_cnt <= m_cnt + CW'(CH_A_I & ~a_q) - CW'(b_en & CH_B_I & ~b_q);
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Result hold and completion flag
  // ----------------------------------------------------------------
  // The closing edge still counts, so capture one edge later, once frozen
  always_ff @(posedge CLOCK_I)
  begin
    if (!NRST_I || wr_mode)
      hold_pend <= 1'b0;
    else
      hold_pend <= enter_hold;
  end

  // Held values change only when a new run ends, even in the middle of a read
  always_ff @(posedge CLOCK_I)
  begin
    if (!NRST_I)
    begin
      a_hold <= '0;
      m_hold <= '0;
    end
    else if (hold_pend)
    begin
      a_hold <= a_cnt;
      m_hold <= m_cnt;
    end
  end

  // Completion wins over an acknowledge in the same cycle
  always_ff @(posedge CLOCK_I)
  begin
    if (!NRST_I || wr_mode)
      done <= 1'b0;
    else if (hold_pend)
      done <= 1'b1;
    else if (cmd_ack)
      done <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Derived results
  // ----------------------------------------------------------------
  assign cur_res   = clamp_exp(avg_exp);
  assign res_exp   = (null_on && off_res < cur_res) ? off_res : cur_res;
  assign scale_exp = (mode inside {MD_TOT_A, MD_TOT_SUM, MD_TOT_DIFF})
                     ? clamp_exp(avg_exp) : 4'h0;
  assign net       = null_on ? m_hold - offset : m_hold;

  always_comb
  begin
    status = '0;
    status[`MMC_ST_DONE]    = done;
    status[`MMC_ST_RUN]     = (state == ST_RUN);
    status[`MMC_ST_NULL]    = null_on;
    status[`MMC_ST_STOPLED] = STOP_LED_O;
    status[`MMC_ST_DITHER]  = DITHER_EN_O;
    status[`MMC_ST_GATE]    = gate;
    status[11:8]            = scale_exp;
    status[15:12]           = res_exp;
    status[26:16]           = mode;
  end

  // ----------------------------------------------------------------
  // Side outputs
  // ----------------------------------------------------------------
  assign DITHER_EN_O   = mode inside {MD_WIDTH, MD_INTERVAL, MD_RISEFALL};
  assign STOP_LED_O    = (mode == MD_MANUAL) & (state != ST_RUN);
  assign COPY_A_TO_B_O = (mode == MD_RISEFALL);
  assign LEVEL_SEL_O   = (mode != MD_RISEFALL) ? 2'h0 :
                         (auto_lvl ? 2'h2 : 2'h1);
  assign DONE_O        = done;

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  always_comb
  begin
    next_err   = 1'b0;
    next_rdata = 32'h00000000;
    unique case (APB_I.paddr)
      `MMC_OFF_MODE:    next_rdata = {21'h000000, mode};
      `MMC_OFF_CONF:    next_rdata = {23'h000000, avg_exp, 2'h0, slope_b_cfg, slope_a};
      `MMC_OFF_CMD:     next_rdata = 32'h00000000;
      `MMC_OFF_STAT:    next_rdata = status;
      `MMC_OFF_ACNT_LO: next_rdata = a_hold[31:0];
      `MMC_OFF_ACNT_HI: next_rdata = {16'h0000, a_hold[CW-1:32]};
      `MMC_OFF_MCNT_LO: next_rdata = m_hold[31:0];
      `MMC_OFF_MCNT_HI: next_rdata = {16'h0000, m_hold[CW-1:32]};
      `MMC_OFF_NET_LO:  next_rdata = net[31:0];
      `MMC_OFF_NET_HI:  next_rdata = {16'h0000, net[CW-1:32]};
      default:          next_err   = 1'b1;
    endcase
  end

  // Answer captured in the setup cycle, shown during the access phase
  always_ff @(posedge CLOCK_I)
  begin
    if (!NRST_I)
    begin
      APB_O.prdata  <= 32'h00000000;
      APB_O.pslverr <= 1'b0;
      APB_O.pready  <= 1'b1;    // Zero wait states, ready from reset on
    end
    else if (rd_setup)
    begin
      APB_O.prdata  <= APB_I.pwrite ? 32'h00000000 : next_rdata;
      APB_O.pslverr <= next_err;
    end
  end


endmodule : mmc_counter

// *** logic/mmc_prng.sv ***
// Pseudo-random bit source that phase-modulates the timebase count
`timescale 1ns/1ns
`include "mmc_cfg.svh"

module mmc_prng (
  input  wire logic CLOCK_I,   // Timebase clock
  input  wire logic NRST_I,    // Synchronous reset, active low
  input  wire logic EN_I,      // Run the generator
  output logic      BIT_O      // Registered random bit
);

  logic [15:0] lfsr;           // Maximal-length shift register

  // ----------------------------------------------------------------
  // Shift register
  // ----------------------------------------------------------------
  // Holds still when disabled so non-dithered modes stay exact
  always_ff @(posedge CLOCK_I)
  begin
    if (!NRST_I)
      lfsr <= `MMC_LFSR_SEED;
    else if (EN_I)
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
  end

  // Output bit, forced low while idle
  always_ff @(posedge CLOCK_I)
  begin
    if (!NRST_I)
      BIT_O <= 1'b0;
    else
      BIT_O <= EN_I & lfsr[15];
  end

endmodule : mmc_prng

// *** shared/mmc_cfg.svh ***
// Offsets, field positions, reset values and timing counts of the measurement counter
`ifndef MMC_CFG_SVH
`define MMC_CFG_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define MMC_CNT_W        48
`define MMC_ADDR_W       8
`define MMC_EXP_W        5

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define MMC_OFF_MODE     8'h00
`define MMC_OFF_CONF     8'h04
`define MMC_OFF_CMD      8'h08
`define MMC_OFF_STAT     8'h0c
`define MMC_OFF_ACNT_LO  8'h10
`define MMC_OFF_ACNT_HI  8'h14
`define MMC_OFF_MCNT_LO  8'h18
`define MMC_OFF_MCNT_HI  8'h1c
`define MMC_OFF_NET_LO   8'h20
`define MMC_OFF_NET_HI   8'h24

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MMC_CONF_SLOPE_A 0
`define MMC_CONF_SLOPE_B 1
`define MMC_CONF_EXP_LO  4
`define MMC_CONF_EXP_HI  8
`define MMC_CMD_NULL     0
`define MMC_CMD_ACK      1
`define MMC_CMD_AUTOLVL  2
`define MMC_ST_DONE      0
`define MMC_ST_RUN       1
`define MMC_ST_NULL      2
`define MMC_ST_STOPLED   3
`define MMC_ST_DITHER    4
`define MMC_ST_GATE      5

// ----------------------------------------------------------------
// Reset values and exponent limits
// ----------------------------------------------------------------
`define MMC_SLOPE_RST    1'b1
`define MMC_EXP_RST      5'h00
`define MMC_EXP_MAX      4'h9
`define MMC_LFSR_SEED    16'hace1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MMC_CLK_PERIOD_NS 10
`define MMC_TB_FREQ_MHZ   320
`define MMC_TB_PERIOD_PS  3125
`define MMC_HUNDREDTH_NS  10000000

`endif

// *** shared/mmc_pkg.sv ***
// Types shared by the measurement counter design files
package mmc_pkg;

  // ----------------------------------------------------------------
  // Measurement functions, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [10:0] {
    MD_FREQ     = 11'h001,
    MD_PERIOD   = 11'h002,
    MD_RATIO    = 11'h004,
    MD_WIDTH    = 11'h008,
    MD_INTERVAL = 11'h010,
    MD_EVENTS   = 11'h020,
    MD_MANUAL   = 11'h040,
    MD_TOT_A    = 11'h080,
    MD_TOT_SUM  = 11'h100,
    MD_TOT_DIFF = 11'h200,
    MD_RISEFALL = 11'h400
  } mmc_mode_t;

  // ----------------------------------------------------------------
  // Measurement sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_WAIT = 3'h1,
    ST_RUN  = 3'h2,
    ST_HOLD = 3'h4
  } mmc_state_t;

  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } mmc_apb_req_t;

  // APB answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } mmc_apb_rsp_t;

endpackage : mmc_pkg

// *** testbench/mmc_chk.sv ***
// Port assertions of the counter
`timescale 1ns/1ns
module mmc_chk (
  input wire logic                  CLOCK_I,
  input wire logic                  NRST_I,
  input wire mmc_pkg::mmc_apb_req_t APB_I,
  input wire logic                  START_STOP_I,
  input wire logic                  RESET_BTN_I,
  input wire logic                  DITHER_EN_O,
  input wire logic                  STOP_LED_O,
  input wire logic                  COPY_A_TO_B_O,
  input wire logic [1:0]            LEVEL_SEL_O,
  input wire logic                  DONE_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!NRST_I);
  // Decoded mode and command writes
  wire w = APB_I.psel & APB_I.penable & APB_I.pwrite;
  wire mw = w & (APB_I.paddr == 8'h00);
  wire cw = w & (APB_I.paddr == 8'h08);
  wire [10:0] d = APB_I.pwdata[10:0];
  sequence s_md(c); mw && d == c; endsequence
  property p_dit; mw && d inside {11'h8, 11'h10, 11'h400} |=> DITHER_EN_O; endproperty
  a_dit: assert property (p_dit) else $error("dither off");
  property p_ndi; s_md(11'h1) |=> !DITHER_EN_O; endproperty
  a_ndi: assert property (p_ndi) else $error("dither on");
  property p_cpy; s_md(11'h400) |=> COPY_A_TO_B_O && LEVEL_SEL_O == 2'b01; endproperty
  a_cpy: assert property (p_cpy) else $error("no copy");
  property p_lvl; cw && APB_I.pwdata[2] && COPY_A_TO_B_O |=> LEVEL_SEL_O == 2'b10; endproperty
  a_lvl: assert property (p_lvl) else $error("no mid level");
  property p_led; s_md(11'h40) |=> STOP_LED_O; endproperty
  a_led: assert property (p_led) else $error("led off");
  property p_clr; mw && $onehot(d) |=> !DONE_O; endproperty
  a_clr: assert property (p_clr) else $error("done kept");
  property p_hld; DONE_O && !mw && !cw && !RESET_BTN_I && !$fell(RESET_BTN_I) |=> DONE_O;
  endproperty
  a_hld: assert property (p_hld) else $error("done lost");
  property p_rb; STOP_LED_O && $fell(RESET_BTN_I) |-> ##[1:2] !STOP_LED_O; endproperty
  a_rb: assert property (p_rb) else $error("no restart");
  property p_ss; STOP_LED_O && !DONE_O && !RESET_BTN_I && $rose(START_STOP_I)
    |-> ##[1:2] !STOP_LED_O; endproperty
  a_ss: assert property (p_ss) else $error("no start");
endmodule : mmc_chk

// *** testbench/mmc_cpu.sv ***
// Processor model on the counter's register bus
`timescale 1ns/1ns
module mmc_cpu (
  input  wire logic                  clk_i, // Bus clock
  output mmc_pkg::mmc_apb_req_t      req_o, // Request
  input  wire mmc_pkg::mmc_apb_rsp_t rsp_i  // Answer
);
  initial req_o = '0;
  // Setup, then access held until ready is sampled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    req_o <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_i);
    req_o.penable <= 1'b1;
    do @(posedge clk_i); while (rsp_i.pready !== 1'b1);
    q = rsp_i.prdata;
    req_o <= '0;
    @(posedge clk_i);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask : rd
endmodule : mmc_cpu

// *** testbench/tb_mmc_counter.sv ***
// Bench of the measurement counter
`timescale 1ns/1ns
module tb_mmc_counter;
  import mmc_pkg::*;
  logic clk = 0;
  logic nrst = 0;
  logic cha = 0;
  logic chb = 0;
  logic ss = 0;
  logic rb = 0;
  mmc_apb_req_t req;
  mmc_apb_rsp_t rsp;
  logic dit, led, cpy, done;
  logic [1:0] lvl;
  logic [31:0] q;
  int failures = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  mmc_counter #(.HUNDREDTH_CYCLES(4)) DUT (.CLOCK_I(clk), .NRST_I(nrst), .APB_I(req),
    .APB_O(rsp), .CH_A_I(cha), .CH_B_I(chb), .START_STOP_I(ss), .RESET_BTN_I(rb),
    .DITHER_EN_O(dit), .STOP_LED_O(led), .COPY_A_TO_B_O(cpy), .LEVEL_SEL_O(lvl),
    .DONE_O(done));
  mmc_cpu cpu (.clk_i(clk), .req_o(req), .rsp_i(rsp));
  task automatic ck(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      failures++;
      $display("unexpected at %0t: %h vs %h", $time, s, e);
    end
  endtask : ck
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    cpu.rd(a, q);
    ck(q, e);
  endtask : rc
  // Button press and release, with time to settle
  task automatic press(input logic r);
    rb <= r;
    ss <= !r;
    repeat (2) @(posedge clk);
    rb <= 1'b0;
    ss <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : press
  task automatic summarize;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  initial
  begin
    logic [31:0] e;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rc(8'h0c, 32'h0001_0000);
    for (int i = 0; i < 11; i++)
    begin
      cpu.wr(8'h00, 32'h1 << i);
      e = (32'h1 << (i + 16)) | ((i inside {3, 4, 10}) ? 32'h10 : 32'h0);
      rc(8'h0c, e | (i == 6 ? 32'h8 : 32'h0));
    end
    $display("test modes done");
    cpu.wr(8'h00, 32'h2);
    cpu.wr(8'h04, 32'h3);
    repeat (2)
    begin
      cha <= 1'b1;
      repeat (10) @(posedge clk);
      cha <= 1'b0;
      repeat (10) @(posedge clk);
    end
    ck(done, 1'b1);
    rc(8'h18, 32'd20);
    rc(8'h10, 32'd1);
    cpu.wr(8'h08, 32'h1);
    rc(8'h20, 32'h0);
    cpu.wr(8'h04, 32'h13);
    cpu.rd(8'h0c, q);
    ck(q[2], 1'b1);
    ck(q[15:12], 4'h0);
    ck(done, 1'b1);
    cpu.wr(8'h08, 32'h2);
    @(posedge clk);
    ck(done, 1'b0);
    cpu.wr(8'h00, 32'h3);
    cpu.rd(8'h0c, q);
    ck(q[2], 1'b1);
    cpu.wr(8'h00, 32'h2);
    cpu.rd(8'h0c, q);
    ck(q[2], 1'b0);
    rc(8'hfc, 32'h0);
    ck(rsp.pslverr, 1'b1);
    $display("test period done");
    cpu.wr(8'h00, 32'h400);
    @(posedge clk);
    ck(lvl, 2'b01);
    ck(cpy, 1'b1);
    cpu.wr(8'h08, 32'h4);
    @(posedge clk);
    ck(lvl, 2'b10);
    cpu.wr(8'h00, 32'h40);
    @(posedge clk);
    ck(led, 1'b1);
    press(1'b0);
    ck(led, 1'b0);
    press(1'b0);
    ck(led, 1'b1);
    press(1'b1);
    ck(led, 1'b0);
    $display("test levels and manual done");
    summarize();
  end
  initial
  begin
    #200000;
    failures++;
    summarize();
  end
endmodule : tb_mmc_counter
bind mmc_counter mmc_chk u_chk (.CLOCK_I(CLOCK_I), .NRST_I(NRST_I), .APB_I(APB_I),
  .START_STOP_I(START_STOP_I), .RESET_BTN_I(RESET_BTN_I), .DITHER_EN_O(DITHER_EN_O),
  .STOP_LED_O(STOP_LED_O), .COPY_A_TO_B_O(COPY_A_TO_B_O), .LEVEL_SEL_O(LEVEL_SEL_O),
  .DONE_O(DONE_O));
